// ===== spi_cfg.svh
// Register offsets, field positions, reset values and bit count of the serial port
`ifndef SPI_CFG_SVH
`define SPI_CFG_SVH
`define ADDR_SHIFT_DATA 8'h19
`define ADDR_CTRL 8'h1A
`define ADDR_CTRL_STATUS 8'h1B
`define CR_IRQ_EN 7
`define CR_PORT_EN 6
`define CR_HALF_DIV_OFF 5
`define CR_MASTER 4
`define CR_IDLE_LEVEL 3
`define CR_PHASE 2
`define CSR_DONE 7
`define CSR_WRITE_COLLISION_FLAG 6
`define CSR_OVR 5
`define CSR_MODE_FAULT_FLAG 4
`define CSR_OUT_DIS 2
`define CSR_SW_SEL 1
`define CSR_SEL_LEVEL 0
`define CTRL_RESET 8'h00
`define STATUS_RESET 8'h00
`define BITS_PER_BYTE 4'h8
`endif

// ===== spi_pkg.sv
// Types shared by the serial port
`default_nettype none
package spi_pkg;
	typedef enum logic {XFER_IDLE, XFER_RUN} xfer_state_t;
endpackage
`default_nettype wire

// ===== spi_status_data.sv
// Serial port status, select handling, shift engine and data buffer
//
// The address-and-strobe port was left to the implementer.
`include "spi_cfg.svh"
`default_nettype none
module spi_status_data
	import spi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] busAddr,
	input wire logic [7:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	output logic [7:0] busRdData,
	output logic irq,
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe,
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOe,
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOe,
	input wire logic selectN
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Two flops per pin: sck, mosi, miso, select
	logic [3:0] s1_reg, s2_reg;
	// Reset to idle pin levels (select high, clock low) so no false clock edge follows reset
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s1_reg <= 4'h8;
			s2_reg <= 4'h8;
		end
		else
		begin
			s1_reg <= {selectN, misoIn, mosiIn, sckIn};
			s2_reg <= s1_reg;
		end
	end
	logic sckS, mosiS, misoS, selPinS;
	assign sckS = s2_reg[0];
	assign mosiS = s2_reg[1];
	assign misoS = s2_reg[2];
	assign selPinS = s2_reg[3];

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	logic [7:0] ctrl_reg, ctrl_next;
	logic done_reg, done_next, write_collision_flag_reg, write_collision_flag_next, ovr_reg, ovr_next, mode_fault_flag_reg, mode_fault_flag_next;
	logic [2:0] csrLow_reg, csrLow_next;
	logic doneArm_reg, doneArm_next, modfArm_reg, modfArm_next, wrUnlock_reg, wrUnlock_next;
	logic [7:0] shift_reg, shift_next, rxBuf_reg, rxBuf_next, rdData_reg, rdData_next;
	xfer_state_t state_reg, state_next;
	logic [3:0] bitCnt_reg, bitCnt_next;
	logic [5:0] div_reg, div_next;
	logic sck_reg, sck_next, sample_reg, sample_next, sckPrev_reg, sckPrev_next;
	logic edgeHalf_reg, edgeHalf_next;

	logic wrData, rdDataAcc, wrCtrl, csrAcc, csrRd;
	assign wrData = busWr && busAddr == `ADDR_SHIFT_DATA;
	assign rdDataAcc = busRd && busAddr == `ADDR_SHIFT_DATA;
	assign wrCtrl = busWr && busAddr == `ADDR_CTRL;
	assign csrRd = busRd && busAddr == `ADDR_CTRL_STATUS;
	assign csrAcc = csrRd || (busWr && busAddr == `ADDR_CTRL_STATUS);

	logic master, portEn, selLow, capture_phase, clock_idle_level;
	assign master = ctrl_reg[`CR_MASTER];
	assign portEn = ctrl_reg[`CR_PORT_EN];
	assign clock_idle_level = ctrl_reg[`CR_IDLE_LEVEL];
	assign capture_phase = ctrl_reg[`CR_PHASE];
	// Internal level replaces the pin under software select
	assign selLow = csrLow_reg[`CSR_SW_SEL] ? ~csrLow_reg[`CSR_SEL_LEVEL] : ~selPinS;

	// Half period in CPU clocks, minus one; at /2 and /4 the receive synchroniser lags the capture edge
	function automatic logic [5:0] halfDiv(input logic [2:0] r);
		case (r)
			3'h4: halfDiv = 6'h00;
			3'h0: halfDiv = 6'h01;
			3'h1: halfDiv = 6'h03;
			3'h6: halfDiv = 6'h07;
			3'h2: halfDiv = 6'h0F;
			3'h3: halfDiv = 6'h1F;
			default: halfDiv = 6'h01;
		endcase
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	logic startXfer, finish, edgeLead, edgeTrail, sckRiseSlave, sckFallSlave, slaveStart;
	always_comb
	begin
		ctrl_next = ctrl_reg;
		done_next = done_reg;
		write_collision_flag_next = write_collision_flag_reg;
		ovr_next = ovr_reg;
		mode_fault_flag_next = mode_fault_flag_reg;
		csrLow_next = csrLow_reg;
		doneArm_next = doneArm_reg;
		modfArm_next = modfArm_reg;
		wrUnlock_next = wrUnlock_reg;
		shift_next = shift_reg;
		rxBuf_next = rxBuf_reg;
		state_next = state_reg;
		bitCnt_next = bitCnt_reg;
		div_next = div_reg;
		sck_next = sck_reg;
		sample_next = sample_reg;
		sckPrev_next = sckS;
		edgeHalf_next = edgeHalf_reg;
		finish = 1'b0;
		edgeLead = 1'b0;
		edgeTrail = 1'b0;
		sckRiseSlave = sckS && !sckPrev_reg;
		sckFallSlave = !sckS && sckPrev_reg;
		// Slave engine must act on its first edge, which already carries data
		slaveStart = !master && state_reg == XFER_IDLE && selLow && portEn && (sckRiseSlave || sckFallSlave);
		// Writes are locked while done is set, until status read
		startXfer = wrData && (!done_reg || wrUnlock_reg);
		rdData_next = 8'h00;
		if (rdDataAcc)
			rdData_next = rxBuf_reg;
		else if (busRd && busAddr == `ADDR_CTRL)
			rdData_next = ctrl_reg;
		else if (csrRd)
			rdData_next = {done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg, 1'b0, csrLow_reg};

		// Register writes
		if (wrCtrl)
			ctrl_next = busWrData;
		if (busWr && busAddr == `ADDR_CTRL_STATUS)
			csrLow_next = busWrData[2:0];

		// Shift engine; clock edges come from divider or pin
		if (state_reg == XFER_IDLE)
			sck_next = clock_idle_level;
		if (master)
		begin
			if (state_reg == XFER_RUN)
			begin
				if (div_reg == 6'h00)
				begin
					div_next = halfDiv({ctrl_reg[`CR_HALF_DIV_OFF], ctrl_reg[1:0]});
					sck_next = ~sck_reg;
					edgeLead = !edgeHalf_reg;
					edgeTrail = edgeHalf_reg;
					edgeHalf_next = ~edgeHalf_reg;
				end
				else
					div_next = div_reg - 6'h01;
			end
		end
		else if (selLow && portEn)
		begin
			edgeLead = clock_idle_level ? sckFallSlave : sckRiseSlave;
			edgeTrail = clock_idle_level ? sckRiseSlave : sckFallSlave;
		end
		// Capture on leading edge when phase 0, trailing when phase 1
		// One shift per period: phase 0 on trailing edges, phase 1 on all leading edges but the first
		if (state_reg == XFER_RUN || slaveStart)
		begin
			if (capture_phase ? edgeTrail : edgeLead)
				sample_next = master ? misoS : mosiS;
			if (capture_phase ? edgeLead : edgeTrail)
			begin
				if (!capture_phase || (bitCnt_reg != `BITS_PER_BYTE && !slaveStart))
					shift_next = {shift_reg[6:0], sample_reg};
			end
			if (edgeTrail)
			begin
				bitCnt_next = bitCnt_reg - 4'h1;
				if (bitCnt_reg == 4'h1)
					finish = 1'b1;
			end
		end
		if (finish)
		begin
			state_next = XFER_IDLE;
			rxBuf_next = capture_phase ? {shift_reg[6:0], master ? misoS : mosiS} : {shift_reg[6:0], sample_reg};
		end
		// A cut frame ends the byte, so a later deselected write does not collide forever
		if (state_reg == XFER_RUN && (!portEn || (!master && !selLow)))
			state_next = XFER_IDLE;
		// Slave becomes busy on first clock edge once selected
		if (slaveStart)
		begin
			state_next = XFER_RUN;
			bitCnt_next = `BITS_PER_BYTE;
		end
		if (startXfer)
		begin
			if (state_reg == XFER_RUN)
				write_collision_flag_next = 1'b1;
			else
			begin
				shift_next = busWrData;
				if (master && portEn)
				begin
					state_next = XFER_RUN;
					bitCnt_next = `BITS_PER_BYTE;
					div_next = halfDiv({ctrl_reg[`CR_HALF_DIV_OFF], ctrl_reg[1:0]});
					edgeHalf_next = 1'b0;
				end
			end
		end
		else if (wrData && state_reg == XFER_RUN)
			write_collision_flag_next = 1'b1;

		// Flag clearing sequences
		if (csrRd)
		begin
			ovr_next = 1'b0;
			wrUnlock_next = 1'b1;
			write_collision_flag_next = 1'b0;
		end
		if (csrAcc && done_reg)
			doneArm_next = 1'b1;
		if (csrAcc && mode_fault_flag_reg)
			modfArm_next = 1'b1;
		if ((wrData || rdDataAcc) && doneArm_reg)
		begin
			done_next = 1'b0;
			doneArm_next = 1'b0;
			wrUnlock_next = 1'b0;
		end
		if (wrCtrl && modfArm_reg)
		begin
			mode_fault_flag_next = 1'b0;
			modfArm_next = 1'b0;
		end
		// Done, overrun and mode fault events win over their clears
		if (finish)
		begin
			if (done_reg && !(doneArm_reg && (wrData || rdDataAcc)))
				ovr_next = 1'b1;
			done_next = 1'b1;
			if (!done_reg)
				wrUnlock_next = 1'b0;
		end
		if (master && portEn && selLow)
		begin
			mode_fault_flag_next = 1'b1;
			ctrl_next[`CR_PORT_EN] = 1'b0;
			ctrl_next[`CR_MASTER] = 1'b0;
			state_next = XFER_IDLE;
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_reg <= `CTRL_RESET;
			{done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg} <= 4'h0;
			csrLow_reg <= 3'h0;
			doneArm_reg <= 1'b0;
			modfArm_reg <= 1'b0;
			wrUnlock_reg <= 1'b0;
			shift_reg <= 8'h00;
			rxBuf_reg <= 8'h00;
			rdData_reg <= 8'h00;
			state_reg <= XFER_IDLE;
			bitCnt_reg <= 4'h0;
			div_reg <= 6'h00;
			sck_reg <= 1'b0;
			sample_reg <= 1'b0;
			sckPrev_reg <= 1'b0;
			edgeHalf_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			done_reg <= done_next;
			write_collision_flag_reg <= write_collision_flag_next;
			ovr_reg <= ovr_next;
			mode_fault_flag_reg <= mode_fault_flag_next;
			csrLow_reg <= csrLow_next;
			doneArm_reg <= doneArm_next;
			modfArm_reg <= modfArm_next;
			wrUnlock_reg <= wrUnlock_next;
			shift_reg <= shift_next;
			rxBuf_reg <= rxBuf_next;
			rdData_reg <= rdData_next;
			state_reg <= state_next;
			bitCnt_reg <= bitCnt_next;
			div_reg <= div_next;
			sck_reg <= sck_next;
			sample_reg <= sample_next;
			sckPrev_reg <= sckPrev_next;
			edgeHalf_reg <= edgeHalf_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic outEn;
	assign outEn = portEn && !csrLow_reg[`CSR_OUT_DIS];
	assign busRdData = rdData_reg;
	assign irq = ctrl_reg[`CR_IRQ_EN] && (done_reg || mode_fault_flag_reg || ovr_reg);
	assign sckOut = sck_reg;
	assign sckOe = portEn && master;
	assign mosiOut = shift_reg[7];
	assign mosiOe = outEn && master;
	assign misoOut = shift_reg[7];
	// Slave drives only while selected, avoiding bus conflicts
	assign misoOe = outEn && !master && selLow;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	done_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(done_reg && ctrl_reg[`CR_IRQ_EN]) |-> irq) else $error("done without irq");
	done_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(done_reg && !doneArm_reg && !finish) |=> done_reg) else $error("done cleared early");
	write_collision_flag_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(wrData && state_reg == XFER_RUN) |=> write_collision_flag_reg) else $error("write_collision_flag missed");
	ovr_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(csrRd && !finish) |=> !ovr_reg) else $error("ovr not cleared");
	mode_fault_flag_fault_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(master && portEn && selLow) |=> (mode_fault_flag_reg && !ctrl_reg[`CR_MASTER] && !ctrl_reg[`CR_PORT_EN]))
		else $error("mode fault handling");
	out_dis_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		csrLow_reg[`CSR_OUT_DIS] |-> (!mosiOe && !misoOe)) else $error("output not released");
	rx_copy_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		rdDataAcc |=> busRdData == $past(rxBuf_reg)) else $error("read not from buffer");
	start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(startXfer && state_reg == XFER_IDLE && master && portEn && !selLow) |=> state_reg == XFER_RUN)
		else $error("no start");
endmodule
`default_nettype wire

// ===== spi_far_model.sv
// Far-side serial slave model: clock idles low, data captured on the first edge
`default_nettype none
module spi_far_model
(
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	input wire logic [7:0] txByte,
	input wire logic load,
	output logic [7:0] rxByte
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sr = 8'h00;

	// Capture on the rising edge, most significant bit first
	always @(posedge sck)
		rxByte <= {rxByte[6:0], mosi};

	// Shift on the falling edge; load puts the MSB out before the first edge
	always @(negedge sck or posedge load)
		if (load)
			sr <= txByte;
		else
			sr <= {sr[6:0], ~sr[0]}; // Stale bits flip so nothing looks valid
	assign miso = sr[7];
endmodule
`default_nettype wire

// ===== test_spi_status_data.sv
// Self-checking bench of the serial port status and data path
`include "spi_cfg.svh"
`default_nettype none
module test_spi_status_data
	import spi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] busAddr = 8'h00;
	logic [7:0] busWrData = 8'h00;
	logic busWr = 1'b0;
	logic busRd = 1'b0;
	logic selectN = 1'b1;
	logic [7:0] farTx = 8'h00;
	logic farLoad = 1'b0;
	logic benchSck = 1'b0;
	logic benchMosi = 1'b0;
	logic [7:0] busRdData, farRx;
	logic irq, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, miso;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	// Bench is master while the port is slave; a released MOSI line shows a flipped value while the port drives the clock
	wire logic sckLine = sckOe ? sckOut : benchSck;
	wire logic mosiLine = mosiOe ? mosiOut : (sckOe ? ~mosiOut : benchMosi);

	spi_status_data i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWrData(busWrData),
		.busWr(busWr), .busRd(busRd), .busRdData(busRdData), .irq(irq), .sckIn(sckLine), .sckOut(sckOut),
		.sckOe(sckOe), .mosiIn(mosiLine), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(miso),
		.misoOut(misoOut), .misoOe(misoOe), .selectN(selectN));
	spi_far_model i_far (.sck(sckLine), .mosi(mosiLine), .miso(miso), .txByte(farTx), .load(farLoad),
		.rxByte(farRx));

	// Clock and hang guard; a full byte at /64 takes about 520 cycles
	initial
		forever #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			summarize();
		end
	end
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		busAddr <= a;
		busWrData <= d;
		busWr <= 1'b1;
		@(posedge sys_clk);
		busWr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		busAddr <= a;
		busRd <= 1'b1;
		@(posedge sys_clk);
		busRd <= 1'b0;
		#1 d = busRdData;
	endtask
	task automatic loadFar(input logic [7:0] d);
		@(posedge sys_clk);
		farTx <= d;
		farLoad <= 1'b1;
		@(posedge sys_clk);
		farLoad <= 1'b0;
	endtask
	// Polling reads the status register, which arms the clear of done
	task automatic waitDone();
		logic [7:0] s;
		for (int i = 0; i < 400; i++)
		begin
			rd(`ADDR_CTRL_STATUS, s);
			if (s[7] === 1'b1)
				return;
		end
		chk(s, 8'h80);
	endtask
	// Time from a rising to a falling serial clock, in CPU clocks
	task automatic halfPeriod(input logic [7:0] want);
		longint t;
		@(posedge sckOut);
		t = $time;
		@(negedge sckOut);
		chk(8'(($time - t) / 10), want);
	endtask
	// Bench clocks one byte into the slave port and checks each bit sent back
	task automatic slaveByte(input logic [7:0] rx, input logic [7:0] tx, input logic capture_phase);
		for (int i = 7; i >= 0; i--)
		begin
			@(posedge sys_clk);
			benchSck <= capture_phase;
			repeat (8) @(posedge sys_clk);
			benchMosi <= rx[i];
			repeat (8) @(posedge sys_clk);
			chk({6'h0, misoOe, misoOut}, {6'h0, 1'b1, tx[i]});
			benchSck <= ~capture_phase;
			repeat (8) @(posedge sys_clk);
			benchSck <= 1'b0;
			repeat (8) @(posedge sys_clk);
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic testReset();
		logic [7:0] v;
		rd(`ADDR_CTRL, v);
		chk(v, `CTRL_RESET);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, `STATUS_RESET);
		rd(8'h00, v);
		chk(v, 8'h00);
		chk({4'h0, irq, sckOe, mosiOe, misoOe}, 8'h00);
	endtask
	// Master byte with a colliding write in flight
	task automatic testXfer();
		logic [7:0] v;
		wr(`ADDR_CTRL, 8'hD3); // Master, /64, interrupt on
		loadFar(8'hA5);
		wr(`ADDR_SHIFT_DATA, 8'h3C);
		wr(`ADDR_SHIFT_DATA, 8'hFF);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v & 8'hC0, 8'h40);
		chk({7'h0, irq}, 8'h00);
		halfPeriod(8'h20);
		waitDone();
		chk(farRx, 8'h3C);
		chk({7'h0, irq}, 8'h01);
		rd(`ADDR_SHIFT_DATA, v);
		chk(v, 8'hA5);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v & 8'hE0, 8'h00);
		chk({7'h0, irq}, 8'h00);
	endtask
	// Data write while done is set and status unread must vanish
	task automatic testIgnore();
		logic [7:0] v;
		loadFar(8'h5A);
		wr(`ADDR_SHIFT_DATA, 8'hC3);
		for (int i = 0; i < 1000 && irq !== 1'b1; i++)
			@(posedge sys_clk);
		wr(`ADDR_SHIFT_DATA, 8'h11);
		repeat (600) @(posedge sys_clk);
		chk(farRx, 8'hC3);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'h80);
		rd(`ADDR_SHIFT_DATA, v);
		chk(v, 8'h5A);
	endtask
	// Select handling, mode fault and output release
	task automatic testFault();
		logic [7:0] v;
		wr(`ADDR_CTRL_STATUS, 8'h07); // Software select, deselected, output off
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'h07);
		chk({7'h0, mosiOe}, 8'h00);
		@(posedge sys_clk);
		selectN <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'h07);
		wr(`ADDR_CTRL_STATUS, 8'h02);
		repeat (5) @(posedge sys_clk);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'h12);
		chk({7'h0, irq}, 8'h01);
		rd(`ADDR_CTRL, v);
		chk(v, 8'h83);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'h12);
		wr(`ADDR_CTRL_STATUS, 8'h03);
		wr(`ADDR_CTRL, 8'h5B); // Master, clock idling high
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'h03);
		chk({5'h0, irq, mosiOe, sckOut}, 8'h03);
		wr(`ADDR_CTRL_STATUS, 8'h00); // Pin select now, pin still low
		repeat (5) @(posedge sys_clk);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'h10);
	endtask
	// Port as slave: both phases, and an overrun from two unread bytes
	task automatic testSlave();
		logic [7:0] v;
		rd(`ADDR_CTRL_STATUS, v);
		wr(`ADDR_CTRL, 8'hC0); // Slave, phase 0, interrupt on
		wr(`ADDR_CTRL_STATUS, 8'h00);
		wr(`ADDR_SHIFT_DATA, 8'h96);
		slaveByte(8'h3A, 8'h96, 1'b0);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'h80);
		slaveByte(8'h5C, 8'h3A, 1'b0);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'hA0);
		chk({7'h0, irq}, 8'h01);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'h80);
		rd(`ADDR_SHIFT_DATA, v);
		wr(`ADDR_CTRL, 8'hC4); // Slave, phase 1
		wr(`ADDR_SHIFT_DATA, 8'hE1);
		slaveByte(8'h69, 8'hE1, 1'b1);
		rd(`ADDR_CTRL_STATUS, v);
		chk(v, 8'h80);
		rd(`ADDR_SHIFT_DATA, v);
		chk(v, 8'h69);
	endtask
	// ----------------------------------------
	// Main sequence and verdict
	// ----------------------------------------
	task automatic summarize();
		if (mismatches == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		testReset();
		testXfer();
		testIgnore();
		testFault();
		testSlave();
		summarize();
	end
endmodule
`default_nettype wire
